// ===== tb_top.sv
// tb_top: self-checking bench for the two-wire programming port
// assumes: tsp_pkg, programmer model and checker compiled before it
`timescale 1ns/1ns
module tb_top;
  import tsp_pkg::*;
  logic         sys_clk, rstn, useSecondPair, outputPhaseEnable;
  logic         cpuInDebug, mClk, mDat, mOe, wireA, wireB;
  logic [31:0]  cpuAddr, seed, wA, wB, a;
  logic         aOut, aOe, bOut, bOe, dSel, bSel, pSel, cSel;
  logic         instrValid, step, flashReq, hold;
  logic [31:0]  instr, flashAddr, lastAddr;
  logic [4:0]   vInstr;
  tsp_flop_type flashOp, lastOp;
  logic [63:0]  got;
  logic [79:0]  raw;
  int           fails, checks_done, reqCnt, n0, vCnt;
  logic [31:0]  corner [12] = '{TSP_DSEG_BASE, TSP_DSEG_LAST,
    TSP_BOOT_BASE, TSP_BOOT_LAST, TSP_CFG_BASE, TSP_PROG_BASE,
    TSP_PROG_LAST, 32'h0, 32'hFFFFFFFF, TSP_DSEG_LAST + 32'h1,
    TSP_BOOT_LAST + 32'h1, TSP_PROG_LAST + 32'h1};

  // data wires with pull-up, fed back to whoever listens
  assign wireA = (mOe && !useSecondPair) ? mDat : (aOe ? aOut : 1'h1);
  assign wireB = (mOe && useSecondPair) ? mDat : (bOe ? bOut : 1'h1);

  tsp_port u_tsp_port (.sys_clk(sys_clk), .rstn(rstn),
    .serialProgClockA(mClk & ~useSecondPair), .serialProgDataAIn(wireA),
    .serialProgDataAOut(aOut), .serialProgDataAOe(aOe),
    .serialProgClockB(mClk & useSecondPair), .serialProgDataBIn(wireB),
    .serialProgDataBOut(bOut), .serialProgDataBOe(bOe),
    .useSecondPair(useSecondPair), .outputPhaseEnable(outputPhaseEnable),
    .cpuInDebug(cpuInDebug), .cpuAddr(cpuAddr), .debugSegSel(dSel),
    .bootSel(bSel), .progSel(pSel), .cfgSel(cSel), .cpuInstr(instr),
    .cpuInstrValid(instrValid), .cpuStep(step), .vendorInstr(vInstr),
    .flashReq(flashReq), .flashOp(flashOp), .flashAddr(flashAddr),
    .cpuResetHold(hold));

  tsp_prog_model u_tsp_prog_model (.fourPhase(outputPhaseEnable),
    .wireIn(useSecondPair ? wireB : wireA), .progClk(mClk),
    .progDat(mDat), .progOe(mOe));

  // 20 MHz clock
  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  // count flash requests, keep the last one
  always @(posedge sys_clk)
  begin
    if (instrValid === 1'h1)
      vCnt++;
    if (flashReq === 1'h1)
    begin
      reqCnt++;
      lastOp = flashOp;
      lastAddr = flashAddr;
    end
  end

  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++)
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic inR(input logic [31:0] x, lo, hi);
    return x >= lo && x <= hi;
  endfunction

  // expected flash operation for an address written to control
  function automatic tsp_flop_type expOp(input logic [31:0] x);
    if (!inR(x, TSP_BOOT_BASE, TSP_BOOT_LAST)
        && !inR(x, TSP_PROG_BASE, TSP_PROG_LAST))
      return TSP_FL_NONE;
    return x[0] ? TSP_FL_ROW : TSP_FL_ERASE;
  endfunction

  task automatic chk(input string what, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one scan from idle to idle, then a flush bit
  task automatic xfer(input logic isIr, input logic [63:0] v, input int n,
                      output logic [63:0] o);
    logic [79:0] tm;
    logic [79:0] ov;
    int          h;
    h = isIr ? 4 : 3;
    tm = isIr ? 80'h3 : 80'h1;
    tm[h + n - 1] = 1'h1;
    tm[h + n] = 1'h1;
    u_tsp_prog_model.run(tm, 80'(v) << h, h + n + 3, ov);
    o = 64'(ov >> h);
  endtask

  task automatic ir(input logic [4:0] v);
    xfer(1'h1, 64'(v), 5, got);
  endtask

  task automatic dr(input logic [31:0] v);
    xfer(1'h0, 64'(v), 32, got);
  endtask

  task automatic setMode(input logic pairB, input logic four);
    @(posedge sys_clk);
    useSecondPair <= pairB;
    outputPhaseEnable <= four;
    @(posedge sys_clk);
  endtask

  // watchdog
  initial
  begin
    #2000000;
    fails++;
    give_verdict();
  end

  initial
  begin
    seed = 32'hFFF9;
    rstn = 1'h0;
    useSecondPair = 1'h0;
    outputPhaseEnable = 1'h1;
    cpuInDebug = 1'h0;
    cpuAddr = 32'h0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk("irReset", 64'(vInstr), 64'(TSP_IR_RESET));
    u_tsp_prog_model.run(80'h1F, 80'h0, 6, raw);
    ir(TSP_IR_CMD_INSTR);
    chk("vendorInstr", 64'(vInstr), 64'(TSP_IR_CMD_INSTR));
    dr(32'(TSP_CMD_ASSERT_RST));
    chk("holdSet", 64'(hold), 64'h1);
    dr(32'(TSP_CMD_DEASSERT));
    chk("holdClr", 64'(hold), 64'h0);
    n0 = reqCnt;
    dr(32'(TSP_CMD_CHIP_ERASE));
    chk("chipReq", 64'(reqCnt - n0), 64'h1);
    chk("chipOp", 64'(lastOp), 64'(TSP_FL_CHIP));
    ir(TSP_IR_SW_DEBUG);
    chk("tapSel", 64'(vInstr), 64'(TSP_IR_BYPASS));
    ir(TSP_IR_DBG_DATA);
    wA = rnd();
    wB = rnd();
    xfer(1'h0, {wB, wA}, 64, got);
    chk("cpuInstr", 64'(instr), 64'(wB));
    chk("instrValid", 64'(vCnt >= 1 && vCnt <= 3), 64'h1);
    chk("dataOut", 64'(got[62:31]), 64'(wA));
    ir(TSP_IR_DBG_CONTROL);
    for (int i = 0; i < 6; i++)
    begin
      wA = rnd();
      case (i % 3)
        0: a = TSP_BOOT_BASE + ((i == 0 ? 32'h17 : wA % 32'h18) << 9)
               + 32'h1;
        1: a = TSP_PROG_BASE + ((wA % 32'h80) << 12);
        default: a = TSP_PROG_LAST + 32'h1 + (wA & 32'h7F000);
      endcase
      n0 = reqCnt;
      dr(a);
      chk("flashReq", 64'(reqCnt - n0),
          64'(expOp(a) != TSP_FL_NONE));
      if (expOp(a) != TSP_FL_NONE)
      begin
        chk("flashOp", 64'(lastOp), 64'(expOp(a)));
        chk("flashAddr", 64'(lastAddr), 64'(a & ~32'h1));
      end
    end
    ir(TSP_IR_SW_VENDOR);
    setMode(1'h0, 1'h0);
    ir(TSP_IR_CMD_INSTR);
    dr(32'(TSP_CMD_ASSERT_RST));
    chk("twoPhase", 64'(hold), 64'h1);
    // frame cut after the update bit: update waits for the next clock
    u_tsp_prog_model.run(80'h1 | (80'h3 << 34),
                         80'(32'(TSP_CMD_DEASSERT)) << 3, 36, raw);
    chk("deferred", 64'(hold), 64'h1);
    u_tsp_prog_model.run(80'h0, 80'h0, 1, raw);
    chk("flushed", 64'(hold), 64'h0);
    setMode(1'h1, 1'h1);
    dr(32'(TSP_CMD_ASSERT_RST));
    chk("pairB", 64'(hold), 64'h1);
    chk("pairBOut", 64'(got[30:0]),
        64'(32'(TSP_CMD_DEASSERT) >> 1));
    for (int i = 0; i < 40; i++)
    begin
      wA = rnd();
      @(posedge sys_clk);
      cpuInDebug <= wA[8];
      cpuAddr <= (i < 12) ? corner[i] : corner[wA[3:0] % 12] ^ wA[7:4];
      @(negedge sys_clk);
      chk("decode", 64'({dSel, bSel, pSel, cSel}),
          64'({cpuInDebug && inR(cpuAddr, TSP_DSEG_BASE, TSP_DSEG_LAST),
          inR(cpuAddr, TSP_BOOT_BASE, TSP_BOOT_LAST),
          inR(cpuAddr, TSP_PROG_BASE, TSP_PROG_LAST),
          inR(cpuAddr, TSP_CFG_BASE, TSP_BOOT_LAST)}));
    end
    give_verdict();
  end
endmodule

// ===== tsp_pkg.sv
// tsp_pkg: shared constants and types for the two-wire programming port
// assumes: included before every design file of the port
package tsp_pkg;

  // tap instruction and data widths
  localparam int TSP_IR_W        = 5;
  localparam int TSP_DR_W        = 32;
  localparam int TSP_CMD_W       = 8;

  // debug tap instruction codes
  localparam logic [4:0] TSP_IR_DBG_DATA    = 5'h09;
  localparam logic [4:0] TSP_IR_DBG_CONTROL = 5'h0A;
  localparam logic [4:0] TSP_IR_BYPASS      = 5'h1F;
  // vendor command tap instruction codes
  localparam logic [4:0] TSP_IR_CMD_INSTR   = 5'h07;
  localparam logic [4:0] TSP_IR_SW_DEBUG    = 5'h05;
  localparam logic [4:0] TSP_IR_SW_VENDOR   = 5'h04;
  // reset value of instruction register
  localparam logic [4:0] TSP_IR_RESET       = 5'h01;

  // debug memory segment window
  localparam logic [31:0] TSP_DSEG_BASE  = 32'hFF200000;
  localparam logic [31:0] TSP_DSEG_LAST  = 32'hFF2FFFFF;
  // boot flash partition
  localparam logic [31:0] TSP_BOOT_BASE  = 32'h1FC00000;
  localparam logic [31:0] TSP_BOOT_LAST  = 32'h1FC02FFF;
  // program flash partition, largest variant
  localparam logic [31:0] TSP_PROG_BASE  = 32'h1D000000;
  localparam logic [31:0] TSP_PROG_LAST  = 32'h1D07FFFF;
  // configuration words: last four words of the boot partition
  localparam logic [31:0] TSP_CFG_BASE   = 32'h1FC02FF0;
  // flash geometry in bytes
  localparam int TSP_PAGE_BYTES = 4096;
  localparam int TSP_ROW_BYTES  = 512;
  localparam logic [31:0] TSP_PAGE_MASK = 32'(TSP_PAGE_BYTES - 1);
  localparam logic [31:0] TSP_ROW_MASK  = 32'(TSP_ROW_BYTES - 1);

  // clock rates
  localparam int TSP_SYS_HZ = 20000000;
  localparam int TSP_CPU_HZ = 8000000;
  // cpu strobe: 8 MHz from 20 MHz by fractional accumulator (2 of 5)
  localparam logic [4:0] TSP_CPU_NUM = 5'(TSP_CPU_HZ / 1000000);
  localparam logic [4:0] TSP_CPU_DEN = 5'(TSP_SYS_HZ / 1000000);

  // phases of one tap bit on the data line
  localparam logic [1:0] TSP_PH_IN   = 2'h0;
  localparam logic [1:0] TSP_PH_MODE = 2'h1;
  localparam logic [1:0] TSP_PH_TURN = 2'h2;
  localparam logic [1:0] TSP_PH_OUT  = 2'h3;

  // flash operations
  typedef enum logic [1:0] {TSP_FL_NONE, TSP_FL_ERASE, TSP_FL_ROW,
                            TSP_FL_CHIP} tsp_flop_type;

  // command byte values for the vendor command tap
  localparam logic [7:0] TSP_CMD_CHIP_ERASE = 8'hFC;
  localparam logic [7:0] TSP_CMD_ASSERT_RST = 8'hD1;
  localparam logic [7:0] TSP_CMD_DEASSERT   = 8'hD0;

endpackage

// ===== tsp_port.sv
// tsp_port: two-wire programming port, converter, debug and vendor taps,
// debug segment decode and a flash operation front end
// assumes: clock and data pins asynchronous to sys_clk, pin clock well
// below a quarter of sys_clk; cpu and flash array sit outside
`timescale 1ns/1ns
module tsp_port
  import tsp_pkg::*;
#(
  parameter int DR_W = TSP_DR_W
)(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              serialProgClockA,
  input  wire logic              serialProgDataAIn,
  output logic                   serialProgDataAOut,
  output logic                   serialProgDataAOe,
  input  wire logic              serialProgClockB,
  input  wire logic              serialProgDataBIn,
  output logic                   serialProgDataBOut,
  output logic                   serialProgDataBOe,
  input  wire logic              useSecondPair,
  input  wire logic              outputPhaseEnable,
  input  wire logic              cpuInDebug,
  input  wire logic [31:0]       cpuAddr,
  output logic                   debugSegSel,
  output logic                   bootSel,
  output logic                   progSel,
  output logic                   cfgSel,
  output logic [31:0]            cpuInstr,
  output logic                   cpuInstrValid,
  output logic                   cpuStep,
  output logic [TSP_IR_W-1:0]    vendorInstr,
  output logic                   flashReq,
  output tsp_flop_type           flashOp,
  output logic [31:0]            flashAddr,
  output logic                   cpuResetHold
);

  // two-flop synchronisers for both pin pairs
  logic [3:0] s1_ff, s2_ff;
  logic       clkPrev_ff;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else
    begin
      s1_ff <= {serialProgDataBIn, serialProgClockB,
                serialProgDataAIn, serialProgClockA};
      s2_ff <= s1_ff;
    end
  end

  // pick the active pair
  logic pinClk, pinData;
  assign pinClk  = useSecondPair ? s2_ff[2] : s2_ff[0];
  assign pinData = useSecondPair ? s2_ff[3] : s2_ff[1];

  logic clkFall;
  assign clkFall = clkPrev_ff & ~pinClk;

  // converter: phase counter, captured mode and data in
  logic [1:0] ph_ff, nxt_ph;
  logic       tdiHold_ff, nxt_tdiHold, tmsHold_ff, nxt_tmsHold;
  logic       pend_ff, nxt_pend, tckR_ff, nxt_tckR, tckF_ff, nxt_tckF;
  logic       drive_ff, nxt_drive, dOut_ff, nxt_dOut;
  logic       tdoBit, tdoAct;

  always_comb
  begin
    nxt_ph      = ph_ff;
    nxt_tdiHold = tdiHold_ff;
    nxt_tmsHold = tmsHold_ff;
    nxt_pend    = pend_ff;
    nxt_tckR    = 1'b0;
    nxt_tckF    = tckR_ff;         // test clock falls one cycle after rise
    nxt_drive   = drive_ff;
    nxt_dOut    = dOut_ff;
    if (clkFall)
    begin
      if (outputPhaseEnable)
      begin
        // four phases per bit
        case (ph_ff)
          TSP_PH_IN:   nxt_tdiHold = pinData;
          TSP_PH_MODE:
          begin
            nxt_tmsHold = pinData;
            nxt_tckR    = 1'b1;
          end
          TSP_PH_TURN:
          begin
            nxt_drive = tdoAct;
            nxt_dOut  = tdoBit;
          end
          TSP_PH_OUT:  nxt_drive = 1'b0;
          default:     nxt_drive = 1'b0;
        endcase
        nxt_ph = 2'(ph_ff + 2'h1);
      end
      else
      begin
        // two phases per bit, applied on next bit's first clock
        nxt_drive = 1'b0;
        if (ph_ff[0] == 1'b0)
        begin
          nxt_tmsHold = pinData;
          nxt_tckR    = pend_ff;
          nxt_pend    = 1'b0;
          nxt_ph      = 2'h1;
        end
        else
        begin
          nxt_tdiHold = pinData;
          nxt_pend    = 1'b1;
          nxt_ph      = 2'h0;
        end
      end
    end
  end

  // hold converter state; tms/tdi for the deferred bit are latched apart
  logic dTms_ff, nxt_dTms, dTdi_ff, nxt_dTdi;
  always_comb
  begin
    nxt_dTms = dTms_ff;
    nxt_dTdi = dTdi_ff;
    if (clkFall && !outputPhaseEnable && ph_ff[0])
    begin
      nxt_dTms = tmsHold_ff;
      nxt_dTdi = pinData;
    end
    else if (clkFall && outputPhaseEnable && ph_ff == TSP_PH_MODE)
    begin
      nxt_dTms = pinData;
      nxt_dTdi = tdiHold_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clkPrev_ff <= 1'b0;
      ph_ff      <= TSP_PH_IN;
      tdiHold_ff <= 1'b0;
      tmsHold_ff <= 1'b1;
      pend_ff    <= 1'b0;
      tckR_ff    <= 1'b0;
      tckF_ff    <= 1'b0;
      drive_ff   <= 1'b0;
      dOut_ff    <= 1'b0;
      dTms_ff    <= 1'b1;
      dTdi_ff    <= 1'b0;
    end
    else
    begin
      clkPrev_ff <= pinClk;
      ph_ff      <= nxt_ph;
      tdiHold_ff <= nxt_tdiHold;
      tmsHold_ff <= nxt_tmsHold;
      pend_ff    <= nxt_pend;
      tckR_ff    <= nxt_tckR;
      tckF_ff    <= nxt_tckF;
      drive_ff   <= nxt_drive;
      dOut_ff    <= nxt_dOut;
      dTms_ff    <= nxt_dTms;
      dTdi_ff    <= nxt_dTdi;
    end
  end

  // data pin drivers, one wire carries tdi and tms, and carries tdo in four-phase mode only
  assign serialProgDataAOut = dOut_ff;
  assign serialProgDataBOut = dOut_ff;
  assign serialProgDataAOe  = drive_ff & ~useSecondPair;
  assign serialProgDataBOe  = drive_ff & useSecondPair;

  // tap: vendor tap first, switch instruction hands over to debug tap
  logic [TSP_IR_W-1:0] irValue;
  logic [DR_W-1:0]     drValue;
  logic                drUpdate;
  tsp_tap #(.DR_W(DR_W)) u_tap (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .tckRise   (tckR_ff),
    .tckFall   (tckF_ff),
    .tms       (dTms_ff),
    .tdi       (dTdi_ff),
    .tdo       (tdoBit),
    .tdoActive (tdoAct),
    .irValue   (irValue),
    .drValue   (drValue),
    .drUpdate  (drUpdate)
  );

  // tap selection, command dispatch, instruction feed, flash front end
  logic         dbgSel_ff, nxt_dbgSel, rstHold_ff, nxt_rstHold;
  logic [31:0]  ins_ff, nxt_ins, fAddr_ff, nxt_fAddr;
  logic         insV_ff, nxt_insV, fReq_ff, nxt_fReq;
  tsp_flop_type fOp_ff, nxt_fOp;
  logic [4:0]   acc_ff, nxt_acc;
  logic         step_ff, nxt_step;
  logic [4:0]   accSum;
  assign accSum = 5'(acc_ff + TSP_CPU_NUM);

  always_comb
  begin
    nxt_dbgSel  = dbgSel_ff;
    nxt_rstHold = rstHold_ff;
    nxt_ins     = ins_ff;
    nxt_insV    = insV_ff;
    nxt_fReq    = 1'b0;
    nxt_fOp     = fOp_ff;
    nxt_fAddr   = fAddr_ff;
    // 8 MHz strobe for the cpu
    nxt_step = accSum >= TSP_CPU_DEN;
    nxt_acc  = nxt_step ? 5'(accSum - TSP_CPU_DEN) : accSum;
    if (step_ff && insV_ff)
      nxt_insV = 1'b0;             // cpu took the word on its strobe
    if (irValue == TSP_IR_SW_DEBUG)
      nxt_dbgSel = 1'b1;
    else if (irValue == TSP_IR_SW_VENDOR)
      nxt_dbgSel = 1'b0;
    if (drUpdate)
    begin
      if (!dbgSel_ff && irValue == TSP_IR_CMD_INSTR)
      begin
        // every update while selected is a new command
        case (drValue[TSP_CMD_W-1:0])
          TSP_CMD_CHIP_ERASE:
          begin
            nxt_fReq  = 1'b1;
            nxt_fOp   = TSP_FL_CHIP;
            nxt_fAddr = TSP_PROG_BASE;
          end
          TSP_CMD_ASSERT_RST: nxt_rstHold = 1'b1;
          TSP_CMD_DEASSERT:   nxt_rstHold = 1'b0;
          default:            nxt_rstHold = rstHold_ff;
        endcase
      end
      else if (dbgSel_ff && irValue == TSP_IR_DBG_DATA)
      begin
        nxt_ins  = drValue[31:0];
        nxt_insV = 1'b1;
      end
      else if (dbgSel_ff && irValue == TSP_IR_DBG_CONTROL)
      begin
        // page erase or row program at a partition address
        nxt_fReq  = (drValue[31:0] >= TSP_PROG_BASE &&
                     drValue[31:0] <= TSP_PROG_LAST) ||
                    (drValue[31:0] >= TSP_BOOT_BASE &&
                     drValue[31:0] <= TSP_BOOT_LAST);
        nxt_fOp   = drValue[0] ? TSP_FL_ROW : TSP_FL_ERASE;
        nxt_fAddr = drValue[0] ? (drValue[31:0] & ~TSP_ROW_MASK)
                               : (drValue[31:0] & ~TSP_PAGE_MASK);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dbgSel_ff  <= 1'b0;
      rstHold_ff <= 1'b0;
      ins_ff     <= '0;
      insV_ff    <= 1'b0;
      fReq_ff    <= 1'b0;
      fOp_ff     <= TSP_FL_NONE;
      fAddr_ff   <= '0;
      acc_ff     <= '0;
      step_ff    <= 1'b0;
    end
    else
    begin
      dbgSel_ff  <= nxt_dbgSel;
      rstHold_ff <= nxt_rstHold;
      ins_ff     <= nxt_ins;
      insV_ff    <= nxt_insV;
      fReq_ff    <= nxt_fReq;
      fOp_ff     <= nxt_fOp;
      fAddr_ff   <= nxt_fAddr;
      acc_ff     <= nxt_acc;
      step_ff    <= nxt_step;
    end
  end

  // address decode toward the cpu bus
  assign debugSegSel = cpuInDebug && cpuAddr >= TSP_DSEG_BASE &&
                       cpuAddr <= TSP_DSEG_LAST;
  assign bootSel = cpuAddr >= TSP_BOOT_BASE &&
                   cpuAddr <= TSP_BOOT_LAST;
  assign progSel = cpuAddr >= TSP_PROG_BASE &&
                   cpuAddr <= TSP_PROG_LAST;
  assign cfgSel  = cpuAddr >= TSP_CFG_BASE &&
                   cpuAddr <= TSP_BOOT_LAST;

  assign cpuInstr      = ins_ff;
  assign cpuInstrValid = insV_ff;
  assign cpuStep       = step_ff;
  assign vendorInstr   = dbgSel_ff ? TSP_IR_BYPASS : irValue;
  assign flashReq      = fReq_ff;
  assign flashOp       = fOp_ff;
  assign flashAddr     = fAddr_ff;
  assign cpuResetHold  = rstHold_ff;

endmodule

// ===== tsp_port_chk.sv
// tsp_port_chk: assertions on the ports of the programming port
// assumes: bound to tsp_port, one sys_clk domain, rstn async low
`timescale 1ns/1ns
module tsp_port_chk
  import tsp_pkg::*;
#(
  parameter int DR_W = TSP_DR_W
)(
  input wire logic         sys_clk,
  input wire logic         rstn,
  input wire logic         serialProgDataAOut,
  input wire logic         serialProgDataAOe,
  input wire logic         serialProgDataBOe,
  input wire logic         useSecondPair,
  input wire logic         outputPhaseEnable,
  input wire logic         cpuInDebug,
  input wire logic [31:0]  cpuAddr,
  input wire logic         debugSegSel,
  input wire logic         bootSel,
  input wire logic         progSel,
  input wire logic         cfgSel,
  input wire logic         cpuStep,
  input wire logic         flashReq,
  input wire tsp_flop_type flashOp,
  input wire logic [31:0]  flashAddr,
  input wire logic         cpuResetHold
);
  logic [3:0] upCnt_ff;
  logic [3:0] nxt_upCnt;

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // cycles since reset, saturating
  always_comb
  begin
    nxt_upCnt = (upCnt_ff == 4'hF) ? upCnt_ff : upCnt_ff + 4'h1;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      upCnt_ff <= 4'h0;
    else
      upCnt_ff <= nxt_upCnt;
  end

  // address decodes
  property p_dseg;
    debugSegSel == (cpuInDebug && cpuAddr >= TSP_DSEG_BASE
                    && cpuAddr <= TSP_DSEG_LAST);
  endproperty
  property p_boot;
    bootSel == (cpuAddr >= TSP_BOOT_BASE && cpuAddr <= TSP_BOOT_LAST);
  endproperty
  property p_prog;
    progSel == (cpuAddr >= TSP_PROG_BASE && cpuAddr <= TSP_PROG_LAST);
  endproperty
  property p_cfg;
    cfgSel == (cpuAddr >= TSP_CFG_BASE && cpuAddr <= TSP_BOOT_LAST);
  endproperty
  // data pin ownership
  property p_two;
    !outputPhaseEnable |-> !serialProgDataAOe && !serialProgDataBOe;
  endproperty
  property p_pair;
    useSecondPair ? !serialProgDataAOe : !serialProgDataBOe;
  endproperty
  property p_oe;
    $rose(serialProgDataAOe) |=>
      (serialProgDataAOe && $stable(serialProgDataAOut)) [*5];
  endproperty
  // flash requests and cpu strobe
  property p_pulse;
    flashReq |=> !flashReq;
  endproperty
  property p_align;
    flashReq |-> flashOp == TSP_FL_CHIP
      || (flashOp == TSP_FL_ROW && (flashAddr & TSP_ROW_MASK) == 32'h0)
      || (flashOp == TSP_FL_ERASE && (flashAddr & TSP_PAGE_MASK) == 32'h0);
  endproperty
  property p_step;
    upCnt_ff > 4'h7 |-> 3'(cpuStep) + 3'($past(cpuStep, 1))
      + 3'($past(cpuStep, 2)) + 3'($past(cpuStep, 3))
      + 3'($past(cpuStep, 4)) == 3'h2;
  endproperty

  a_dseg: assert property (p_dseg) else $error("bad dseg");
  a_boot: assert property (p_boot) else $error("bad boot");
  a_prog: assert property (p_prog) else $error("bad prog");
  a_cfg: assert property (p_cfg) else $error("bad cfg");
  a_two: assert property (p_two) else $error("oe in 2ph");
  a_pair: assert property (p_pair) else $error("oe pair");
  a_oe: assert property (p_oe) else $error("oe short");
  a_pulse: assert property (p_pulse) else $error("req long");
  a_align: assert property (p_align) else $error("req align");
  a_step: assert property (p_step) else $error("step rate");

  c_req: cover property (flashReq);
  c_hold: cover property ($rose(cpuResetHold));
  c_oeA: cover property ($rose(serialProgDataAOe));
  c_oeB: cover property ($rose(serialProgDataBOe));
endmodule

bind tsp_port tsp_port_chk #(.DR_W(DR_W)) u_tsp_port_chk (
  .sys_clk(sys_clk), .rstn(rstn), .serialProgDataAOut(serialProgDataAOut),
  .serialProgDataAOe(serialProgDataAOe),
  .serialProgDataBOe(serialProgDataBOe), .useSecondPair(useSecondPair),
  .outputPhaseEnable(outputPhaseEnable), .cpuInDebug(cpuInDebug),
  .cpuAddr(cpuAddr), .debugSegSel(debugSegSel), .bootSel(bootSel),
  .progSel(progSel), .cfgSel(cfgSel), .cpuStep(cpuStep),
  .flashReq(flashReq), .flashOp(flashOp), .flashAddr(flashAddr),
  .cpuResetHold(cpuResetHold)
);

// ===== tsp_prog_model.sv
// tsp_prog_model: behavioural programmer on one clock/data pin pair
// assumes: bench resolves the data wire with a pull-up into wireIn
`timescale 1ns/1ns
module tsp_prog_model (
  input  wire logic fourPhase,
  input  wire logic wireIn,
  output logic      progClk,
  output logic      progDat,
  output logic      progOe
);
  // idle: clock stands low, data released
  initial
  begin
    progClk = 1'h0;
    progDat = 1'h0;
    progOe = 1'h0;
  end

  // one 400 ns clock; line looked at 150 ns after the rise
  // pins move by non-blocking update so an edge-aligned call does not race
  task automatic phase(input logic drv, input logic v, output logic seen);
    progClk <= 1'h1;
    #150;
    seen = wireIn;
    progOe <= drv;
    progDat <= drv ? v : ~progDat;
    #50;
    progClk <= 1'h0;
    #200;
  endtask

  // clock a frame of tap bits, lsb first
  task automatic run(input logic [79:0] tm, input logic [79:0] td,
                     input int n, output logic [79:0] ov);
    logic s;
    ov = '0;
    for (int i = 0; i < n; i++)
    begin
      if (fourPhase)
      begin
        phase(1'h1, td[i], s);
        phase(1'h1, tm[i], s);
        phase(1'h0, 1'h0, s);
        phase(1'h0, 1'h0, s);
        ov[i] = s;
      end
      else
      begin
        phase(1'h1, tm[i], s);
        phase(1'h1, td[i], s);
      end
    end
    progOe <= 1'h0;
  endtask
endmodule

// ===== tsp_tap.sv
// tsp_tap: tap state machine with instruction and data shift registers
// assumes: one-cycle tckRise/tckFall strobes derived in sys_clk domain
`timescale 1ns/1ns
module tsp_tap
  import tsp_pkg::*;
#(
  parameter int DR_W = TSP_DR_W
)(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              tckRise,
  input  wire logic              tckFall,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdoActive,
  output logic [TSP_IR_W-1:0]    irValue,
  output logic [DR_W-1:0]        drValue,
  output logic                   drUpdate
);

  typedef enum logic [3:0] {TR, RTI, SELDR, CAPDR, SHDR, EX1DR, PSDR,
                            EX2DR, UPDR, SELIR, CAPIR, SHIR, EX1IR, PSIR,
                            EX2IR, UPIR} tsp_tst_type;

  tsp_tst_type              st_ff, nxt_st;
  logic [TSP_IR_W-1:0]      irSh_ff, nxt_irSh, ir_ff, nxt_ir;
  logic [DR_W-1:0]          drSh_ff, nxt_drSh, dr_ff, nxt_dr;
  logic                     tdo_ff, nxt_tdo, act_ff, nxt_act, upd_ff, nxt_upd;

  // next state, mode select picks instruction or data path
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_irSh = irSh_ff;
    nxt_ir   = ir_ff;
    nxt_drSh = drSh_ff;
    nxt_dr   = dr_ff;
    nxt_tdo  = tdo_ff;
    nxt_act  = act_ff;
    nxt_upd  = 1'b0;
    if (tckRise)
    begin
      case (st_ff)
        TR:    nxt_st = tms ? TR : RTI;
        RTI:   nxt_st = tms ? SELDR : RTI;
        SELDR: nxt_st = tms ? SELIR : CAPDR;
        CAPDR: nxt_st = tms ? EX1DR : SHDR;
        SHDR:  nxt_st = tms ? EX1DR : SHDR;
        EX1DR: nxt_st = tms ? UPDR : PSDR;
        PSDR:  nxt_st = tms ? EX2DR : PSDR;
        EX2DR: nxt_st = tms ? UPDR : SHDR;
        UPDR:  nxt_st = tms ? SELDR : RTI;
        SELIR: nxt_st = tms ? TR : CAPIR;
        CAPIR: nxt_st = tms ? EX1IR : SHIR;
        SHIR:  nxt_st = tms ? EX1IR : SHIR;
        EX1IR: nxt_st = tms ? UPIR : PSIR;
        PSIR:  nxt_st = tms ? EX2IR : PSIR;
        EX2IR: nxt_st = tms ? UPIR : SHIR;
        UPIR:  nxt_st = tms ? SELDR : RTI;
        default: nxt_st = TR;
      endcase
      // shift and capture on the sampled data bit, lsb first
      case (st_ff)
        CAPDR: nxt_drSh = dr_ff;
        SHDR:  nxt_drSh = {tdi, drSh_ff[DR_W-1:1]};
        CAPIR: nxt_irSh = TSP_IR_RESET;
        SHIR:  nxt_irSh = {tdi, irSh_ff[TSP_IR_W-1:1]};
        default: nxt_irSh = irSh_ff;
      endcase
      if (st_ff == TR)
        nxt_ir = TSP_IR_RESET;
    end
    if (tckFall)
    begin
      // output changes on the falling clock
      nxt_act = (st_ff == SHDR) || (st_ff == SHIR);
      nxt_tdo = (st_ff == SHIR) ? irSh_ff[0] : drSh_ff[0];
      if (st_ff == UPIR)
        nxt_ir = irSh_ff;
      if (st_ff == UPDR)
      begin
        nxt_dr  = drSh_ff;
        nxt_upd = 1'b1;
      end
    end
  end

  // register tap state
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff   <= TR;
      irSh_ff <= '0;
      ir_ff   <= TSP_IR_RESET;
      drSh_ff <= '0;
      dr_ff   <= '0;
      tdo_ff  <= 1'b0;
      act_ff  <= 1'b0;
      upd_ff  <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      irSh_ff <= nxt_irSh;
      ir_ff   <= nxt_ir;
      drSh_ff <= nxt_drSh;
      dr_ff   <= nxt_dr;
      tdo_ff  <= nxt_tdo;
      act_ff  <= nxt_act;
      upd_ff  <= nxt_upd;
    end
  end

  assign tdo       = tdo_ff;
  assign tdoActive = act_ff;
  assign irValue   = ir_ff;
  assign drValue   = dr_ff;
  assign drUpdate  = upd_ff;

endmodule
